// ---- bench/dcte_mem_model.sv ----
// memory-side partner: turns each issued write into a final write data
// marker a fixed number of cycles after the write shows on the command bus.
// assumes it sees the command bus on the controller clock.
`timescale 1ns/1ps
`default_nettype none

module dcte_mem_model
   import dcte_pkg::*;
#(
   parameter int WR_DATA_LAT = 3
)
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   // command bus from the controller
   input  wire dcte_cmd_type           cmd_i,
   // final write data transfer
   output logic                        wr_last_o,
   output logic [DCTE_BANK_W-1:0]      wr_last_bank_o
);
   typedef struct packed {
      logic [WR_DATA_LAT-1:0]                  vld;
      logic [WR_DATA_LAT-1:0][DCTE_BANK_W-1:0] bank;
   } dcte_mdl_state_type;

   dcte_mdl_state_type state;
   dcte_mdl_state_type next_state;

   ////////////////////////////////////////////////////////
   // burst pipeline; fixed latency, a real burst may vary
   always_comb
   begin
      next_state      = state;
      next_state.vld  = {state.vld[WR_DATA_LAT-2:0], cmd_i.valid && cmd_i.kind == DCTE_WR};
      next_state.bank = {state.bank[WR_DATA_LAT-2:0], cmd_i.bank};
      if (!rst_n_i)
      begin
         next_state = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      state <= next_state;
   end

   // marker is one cycle wide, bank travels beside it
   assign wr_last_o      = state.vld[WR_DATA_LAT-1];
   assign wr_last_bank_o = state.bank[WR_DATA_LAT-1];
endmodule : dcte_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench of the command timing enforcer with a memory-side model.
// assumes 100 MHz and a model write data latency of three cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import dcte_pkg::*;
;
   localparam int WR_LAT = 3;
   localparam int WTR = 2, RRD = 3, RC = 6, RAS = 4, WRC = 1;
   localparam int RTW = 2, RP = 3, RCD = 1;
   localparam logic [31:0] T1 = 32'((WRC << WR_RECOVERY_LSB) | (RAS << ROW_ACTIVE_LSB)
                                | (RC << ROW_CYCLE_LSB) | (RRD << BANK_ACT_LSB) | WTR);
   localparam logic [31:0] T2 = 32'((RTW << RD_TO_WR_LSB) | (RP << PRE_PERIOD_LSB) | RCD);

   typedef struct {
      dcte_cmd_kind_type ka;
      logic [2:0]        ba;
      dcte_cmd_kind_type kb;
      logic [2:0]        bb;
      int                gap;
   } dcte_row_type;

   logic             clk_i;
   logic             rst_n_i;
   dcte_bus_req_type bus;
   logic [31:0]      rd_data_o;
   dcte_cmd_type     req;
   logic             req_ready_o;
   logic             wr_last;
   logic [2:0]       wr_last_bank;
   dcte_cmd_type     mem_cmd_o;
   dcte_cmd_type     acc_cmd;
   logic             acc_seen;
   logic             mon_on;
   int               cyc = 0;
   int               t0;
   int               t1;
   int               mismatches;
   int               comparisons;

   // first command, second command, accept-to-accept distance
   dcte_row_type rows [12] = '{
      '{DCTE_ACT, 3'h0, DCTE_RD,  3'h0, RCD + 1},
      '{DCTE_ACT, 3'h1, DCTE_WR,  3'h1, RCD + 1},
      '{DCTE_ACT, 3'h0, DCTE_PRE, 3'h0, RAS + 1},
      '{DCTE_ACT, 3'h2, DCTE_ACT, 3'h2, RC + 1},
      '{DCTE_ACT, 3'h0, DCTE_ACT, 3'h3, RRD + 1},
      '{DCTE_PRE, 3'h4, DCTE_ACT, 3'h4, RP + 1},
      '{DCTE_PRE, 3'h5, DCTE_REF, 3'h0, RP + 1},
      '{DCTE_RD,  3'h0, DCTE_WR,  3'h6, RTW + 1},
      '{DCTE_ACT, 3'h1, DCTE_RD,  3'h2, 1},
      '{DCTE_PRE, 3'h4, DCTE_ACT, 3'h5, 1},
      '{DCTE_WR,  3'h3, DCTE_RD,  3'h0, WR_LAT + WTR + 2},
      '{DCTE_WR,  3'h3, DCTE_PRE, 3'h3, WR_LAT + WRC + 2}};

   dcte_enforcer i_dcte_enforcer (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
      .rd_data_o(rd_data_o), .req_i(req), .req_ready_o(req_ready_o), .wr_last_i(wr_last),
      .wr_last_bank_i(wr_last_bank), .mem_cmd_o(mem_cmd_o));

   dcte_mem_model #(.WR_DATA_LAT(WR_LAT)) i_dcte_mem_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cmd_i(mem_cmd_o), .wr_last_o(wr_last), .wr_last_bank_o(wr_last_bank));

   // free-running clock and cycle count
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // edge-aligned strobes; one idle cycle between accesses
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus <= '0;
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_i);
      bus <= '0;
      @(negedge clk_i);
      check(rd_data_o, e);
   endtask : bus_read

   // request held until ready is seen; ready sampled mid-cycle to avoid races
   task automatic issue(input dcte_cmd_kind_type k, input logic [2:0] b, output int t);
      int n;
      n = 0;
      req <= '{1'b1, k, b};
      @(negedge clk_i);
      while (req_ready_o !== 1'b1 && n < 600)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 600)
         check(32'h0, 32'h1);
      @(posedge clk_i);
      t        = cyc;
      acc_cmd  = '{1'b1, k, b};
      acc_seen = 1'b1;
   endtask : issue

   task automatic run_row(input dcte_cmd_kind_type ka, input logic [2:0] ba,
                          input dcte_cmd_kind_type kb, input logic [2:0] bb, input int gap);
      int ta;
      int tb;
      issue(ka, ba, ta);
      issue(kb, bb, tb);
      req <= '0;
      check(32'(tb - ta), 32'(gap));
      repeat (40) @(posedge clk_i);
      $display("spacing case done, gap %0d", gap);
   endtask : run_row

   // command bus shows each accepted command for exactly one cycle
   always @(negedge clk_i)
   begin
      if (mon_on)
      begin
         if (acc_seen)
            check(32'(mem_cmd_o), 32'(acc_cmd));
         else
            check(32'(mem_cmd_o), 32'h0);
         acc_seen = 1'b0;
      end
   end

   // hang guard, far beyond the well under two thousand cycles the run needs
   initial
   begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end

   ////////////////////////////////////////////////////////
   initial
   begin
      clk_i       = 1'b0;
      rst_n_i     = 1'b0;
      bus         = '0;
      req         = '0;
      acc_seen    = 1'b0;
      mon_on      = 1'b0;
      mismatches  = 0;
      comparisons = 0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      mon_on = 1'b1;
      // reset values, reserved bits, unmapped address
      bus_read(ROW_TIMING_ONE_OFS, ROW_TIMING_ONE_RESET);
      bus_read(ROW_TIMING_TWO_OFS, ROW_TIMING_TWO_RESET);
      bus_write(ROW_TIMING_ONE_OFS, 32'hffff_ffff);
      bus_read(ROW_TIMING_ONE_OFS, 32'h3fff_ffff);
      bus_write(ROW_TIMING_TWO_OFS, 32'hffff_ffff);
      bus_read(ROW_TIMING_TWO_OFS, 32'h0000_1fff);
      bus_write(8'h08, 32'h1234_5678);
      bus_read(8'h08, 32'h0);
      $display("register test done");
      // all-ones fields: largest spacings
      @(posedge clk_i);
      run_row(DCTE_ACT, 3'h7, DCTE_RD, 3'h7, 32'h1f + 32'h1);
      run_row(DCTE_ACT, 3'h6, DCTE_ACT, 3'h5, 32'h3f + 32'h1);
      run_row(DCTE_ACT, 3'h4, DCTE_ACT, 3'h4, 32'hff + 32'h1);
      repeat (300) @(posedge clk_i);
      bus_write(ROW_TIMING_ONE_OFS, T1);
      bus_write(ROW_TIMING_TWO_OFS, T2);
      bus_read(ROW_TIMING_ONE_OFS, T1);
      bus_read(ROW_TIMING_TWO_OFS, T2);
      @(posedge clk_i);
      foreach (rows[i])
         run_row(rows[i].ka, rows[i].ba, rows[i].kb, rows[i].bb, rows[i].gap);
      // reset in mid-run: timers idle and row_timing_one back to its reset value
      issue(DCTE_ACT, 3'h2, t0);
      req     <= '0;
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t0 = cyc;
      issue(DCTE_ACT, 3'h2, t1);
      req <= '0;
      check(32'(t1 - t0), 32'h1);
      bus_read(ROW_TIMING_ONE_OFS, ROW_TIMING_ONE_RESET);
      $display("mid-run reset test done");
      repeat (2) @(posedge clk_i);
      conclude();
   end
endmodule : tb_top
`default_nettype wire

// ---- hdl/dcte_enforcer.sv ----
// ddr3 command timing enforcer: timing registers plus per-bank and bus-wide
// spacing timers that hold back commands until they are legal.
// assumes requester, write-data tracker and register master share clk_i.
//
// Behaviour
// - precharge waits write recovery plus one
// - activate to precharge spacing row-active plus one
// - same-bank activates spaced row-cycle plus one
// - any activates spaced bank-to-bank plus one
// - read waits write-to-read plus one
// - write waits read-to-write turnaround plus one
// - activate or refresh waits precharge period plus one
// - read or write waits activate-to-access plus one
// - reserved bits read zero, writes ignored
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dcte_enforcer
   import dcte_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   // register port
   input  wire dcte_bus_req_type       bus_i,
   output logic [31:0]                 rd_data_o,
   // command request from scheduler
   input  wire dcte_cmd_type           req_i,
   output logic                        req_ready_o,
   // final write data transfer marker
   input  wire logic                   wr_last_i,
   input  wire logic [DCTE_BANK_W-1:0] wr_last_bank_i,
   // command toward the memory command bus
   output dcte_cmd_type                mem_cmd_o
);

   typedef struct packed {
      logic [31:0]  tim1;
      logic [31:0]  tim2;
      logic [31:0]  rd_data;
      dcte_cmd_type cmd;
      logic [DCTE_BANKS-1:0][1:0] wr_pend;
   } dcte_state_type;

   dcte_state_type s;
   dcte_state_type next_s;

   logic                  take;
   logic [DCTE_BANKS-1:0] act_ok;
   logic [DCTE_BANKS-1:0] pre_ok;
   logic [DCTE_BANKS-1:0] acc_ok;
   logic [DCTE_BANKS-1:0] rp_busy;
   logic                  rrd_busy;
   logic                  wtr_busy;
   logic                  rtw_busy;
   logic                  act_any;
   logic                  rd_take;
   logic [DCTE_BANKS-1:0] bank_act;
   logic [DCTE_BANKS-1:0] bank_pre;
   logic [DCTE_BANKS-1:0] bank_wl;
   logic [DCTE_BANKS-1:0] bank_wt;
   logic [DCTE_BANKS-1:0] wr_idle;

   ////////////////////////////////////////////////////////////////////////////
   // field extraction, widened to the timer width
   logic [DCTE_CNT_W-1:0] wr_val;
   logic [DCTE_CNT_W-1:0] ras_val;
   logic [DCTE_CNT_W-1:0] rc_val;
   logic [DCTE_CNT_W-1:0] rrd_val;
   logic [DCTE_CNT_W-1:0] wtr_val;
   logic [DCTE_CNT_W-1:0] rtw_val;
   logic [DCTE_CNT_W-1:0] rp_val;
   logic [DCTE_CNT_W-1:0] rcd_val;

   assign wr_val  = {3'h0, s.tim1[WR_RECOVERY_LSB +: WR_RECOVERY_W]};
   assign ras_val = {1'h0, s.tim1[ROW_ACTIVE_LSB +: ROW_ACTIVE_W]};
   assign rc_val  = s.tim1[ROW_CYCLE_LSB +: ROW_CYCLE_W];
   assign rrd_val = {2'h0, s.tim1[BANK_ACT_LSB +: BANK_ACT_W]};
   assign wtr_val = {4'h0, s.tim1[WR_TO_RD_LSB +: WR_TO_RD_W]};
   assign rtw_val = {5'h0, s.tim2[RD_TO_WR_LSB +: RD_TO_WR_W]};
   assign rp_val  = {3'h0, s.tim2[PRE_PERIOD_LSB +: PRE_PERIOD_W]};
   assign rcd_val = {3'h0, s.tim2[ACT_ACCESS_LSB +: ACT_ACCESS_W]};

   ////////////////////////////////////////////////////////////////////////////
   // acceptance of a request
   assign take    = req_i.valid && req_ready_o;
   assign act_any = take && (req_i.kind == DCTE_ACT);
   assign rd_take = take && (req_i.kind == DCTE_RD);

   // gate by kind; nop and unknown kinds pass freely
   always_comb
   begin
      case (req_i.kind)
         DCTE_ACT: req_ready_o = act_ok[req_i.bank] && !rrd_busy;
         DCTE_PRE: req_ready_o = pre_ok[req_i.bank];
         DCTE_RD:  req_ready_o = acc_ok[req_i.bank] && !wtr_busy && (wr_idle == '1);
         // a full pending count stalls further writes so it never wraps
         DCTE_WR:  req_ready_o = acc_ok[req_i.bank] && !rtw_busy &&
                                 (s.wr_pend[req_i.bank] != 2'h3);
         DCTE_REF: req_ready_o = (rp_busy == '0);
         default:  req_ready_o = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-bank row timers; a command to one bank never loads another bank's
   generate
      for (genvar b = 0; b < DCTE_BANKS; b++)
      begin : g_bank
         logic act_b;
         logic pre_b;
         logic wl_b;
         logic rc_busy;
         logic ras_busy;
         logic rcd_busy;
         logic wr_busy;

         assign act_b = act_any && (req_i.bank == DCTE_BANK_W'(b));
         assign pre_b = take && (req_i.kind == DCTE_PRE) &&
                        (req_i.bank == DCTE_BANK_W'(b));
         assign wl_b  = wr_last_i && (wr_last_bank_i == DCTE_BANK_W'(b));

         // flat copies for procedural loops, which cannot index generate scopes
         assign bank_act[b] = act_b;
         assign bank_pre[b] = pre_b;
         assign bank_wl[b]  = wl_b;
         assign bank_wt[b]  = take && (req_i.kind == DCTE_WR) &&
                              (req_i.bank == DCTE_BANK_W'(b));
         assign wr_idle[b]  = (s.wr_pend[b] == 2'h0);

         dcte_timer u_rc (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .load_i  (act_b),
            .value_i (rc_val),
            .busy_o  (rc_busy)
         );

         dcte_timer u_ras (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .load_i  (act_b),
            .value_i (ras_val),
            .busy_o  (ras_busy)
         );

         dcte_timer u_rcd (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .load_i  (act_b),
            .value_i (rcd_val),
            .busy_o  (rcd_busy)
         );

         dcte_timer u_rp (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .load_i  (pre_b),
            .value_i (rp_val),
            .busy_o  (rp_busy[b])
         );

         dcte_timer u_wr (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .load_i  (wl_b),
            .value_i (wr_val),
            .busy_o  (wr_busy)
         );

         assign act_ok[b] = !rc_busy && !rp_busy[b];
         assign pre_ok[b] = !ras_busy && !wr_busy && wr_idle[b];
         assign acc_ok[b] = !rcd_busy;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // bus-wide timers shared by all banks
   dcte_timer u_rrd (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (act_any),
      .value_i (rrd_val),
      .busy_o  (rrd_busy)
   );

   // write-to-read counts from the final data beat, not the write command
   dcte_timer u_wtr (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (wr_last_i),
      .value_i (wtr_val),
      .busy_o  (wtr_busy)
   );

   dcte_timer u_rtw (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (rd_take),
      .value_i (rtw_val),
      .busy_o  (rtw_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // registers and command output
   always_comb
   begin
      next_s         = s;
      next_s.cmd     = '0;
      next_s.rd_data = '0;
      if (take)
      begin
         next_s.cmd = req_i;
      end
      // writes whose final data beat has not come yet; the timers only start
      // at that beat, so reads and precharges must wait for it as well
      for (int i = 0; i < DCTE_BANKS; i++)
      begin
         if (bank_wt[i] && !bank_wl[i])
         begin
            next_s.wr_pend[i] = s.wr_pend[i] + 2'h1;
         end
         else if (!bank_wt[i] && bank_wl[i] && (s.wr_pend[i] != 2'h0))
         begin
            next_s.wr_pend[i] = s.wr_pend[i] - 2'h1;
         end
      end
      if (bus_i.wr && (bus_i.addr == ROW_TIMING_ONE_OFS))
      begin
         next_s.tim1 = bus_i.wdata & ROW_TIMING_ONE_MASK;
      end
      if (bus_i.wr && (bus_i.addr == ROW_TIMING_TWO_OFS))
      begin
         next_s.tim2 = bus_i.wdata & ROW_TIMING_TWO_MASK;
      end
      // unmapped reads answer zero
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            ROW_TIMING_ONE_OFS: next_s.rd_data = s.tim1;
            ROW_TIMING_TWO_OFS: next_s.rd_data = s.tim2;
            default:            next_s.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s.tim1    <= ROW_TIMING_ONE_RESET;
         s.tim2    <= ROW_TIMING_TWO_RESET;
         s.rd_data <= '0;
         s.cmd     <= '0;
         s.wr_pend <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rd_data;
   assign mem_cmd_o = s.cmd;

   ////////////////////////////////////////////////////////////////////////////
   // helper: cycles since each event, saturating, for checks only
   logic [8:0] since_act [DCTE_BANKS];
   logic [8:0] since_pre [DCTE_BANKS];
   logic [8:0] since_wl  [DCTE_BANKS];
   logic [8:0] since_any_act;
   logic [8:0] since_any_wl;
   logic [8:0] since_rd;

   function automatic logic [8:0] dcte_step(input logic ev, input logic [8:0] v);
      if (ev)
      begin
         return 9'h001;
      end
      return (v == 9'h1ff) ? v : v + 9'h001;
   endfunction : dcte_step

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         since_any_act <= 9'h1ff;
         since_any_wl  <= 9'h1ff;
         since_rd      <= 9'h1ff;
         for (int i = 0; i < DCTE_BANKS; i++)
         begin
            since_act[i] <= 9'h1ff;
            since_pre[i] <= 9'h1ff;
            since_wl[i]  <= 9'h1ff;
         end
      end
      else
      begin
         since_any_act <= dcte_step(act_any, since_any_act);
         since_any_wl  <= dcte_step(wr_last_i, since_any_wl);
         since_rd      <= dcte_step(rd_take, since_rd);
         for (int i = 0; i < DCTE_BANKS; i++)
         begin
            since_act[i] <= dcte_step(bank_act[i], since_act[i]);
            since_pre[i] <= dcte_step(bank_pre[i], since_pre[i]);
            since_wl[i]  <= dcte_step(bank_wl[i], since_wl[i]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking dcte_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   rc_same_bank_a : assert property (act_any |->
      since_act[req_i.bank] > {1'b0, rc_val})
      else $error("same-bank activates too close");

   rrd_spacing_a : assert property (act_any |-> since_any_act > {1'b0, rrd_val})
      else $error("activates too close across banks");

   ras_spacing_a : assert property ((take && req_i.kind == DCTE_PRE) |->
      since_act[req_i.bank] > {1'b0, ras_val})
      else $error("precharge too soon after activate");

   wr_recovery_a : assert property ((take && req_i.kind == DCTE_PRE) |->
      since_wl[req_i.bank] > {1'b0, wr_val})
      else $error("precharge inside write recovery");

   rcd_access_a : assert property ((take && (req_i.kind == DCTE_RD ||
      req_i.kind == DCTE_WR)) |-> since_act[req_i.bank] > {1'b0, rcd_val})
      else $error("access too soon after activate");

   rp_period_a : assert property (act_any |->
      since_pre[req_i.bank] > {1'b0, rp_val})
      else $error("activate inside precharge period");

   wtr_turn_a : assert property (rd_take |-> since_any_wl > {1'b0, wtr_val})
      else $error("read too soon after write data");

   rtw_turn_a : assert property ((take && req_i.kind == DCTE_WR) |->
      since_rd > {1'b0, rtw_val})
      else $error("write too soon after read");

   rsvd_read_a : assert property (bus_i.rd |=>
      ($past(bus_i.addr) != ROW_TIMING_ONE_OFS || rd_data_o[31:30] == 2'h0) &&
      ($past(bus_i.addr) != ROW_TIMING_TWO_OFS || rd_data_o[31:13] == 19'h0))
      else $error("reserved bits read nonzero");

   cmd_issue_a : assert property (take |=> mem_cmd_o.valid &&
      mem_cmd_o.kind == $past(req_i.kind) && mem_cmd_o.bank == $past(req_i.bank))
      else $error("accepted command not issued");

   wr_pend_rd_a : assert property (rd_take |-> (wr_idle == '1))
      else $error("read issued while write data still pending");

   stall_act_c : cover property (req_i.valid && req_i.kind == DCTE_ACT && !req_ready_o);
   rd_wait_wr_c : cover property (req_i.valid && req_i.kind == DCTE_RD && wr_idle != '1);
   two_bank_c  : cover property (act_any ##1 !act_any [*2] ##1 act_any);
   rd_wr_c     : cover property (rd_take ##[1:20] (take && req_i.kind == DCTE_WR));

endmodule : dcte_enforcer

`default_nettype wire

// ---- hdl/dcte_pkg.sv ----
// package of the ddr3 command timing enforcer: register map, field layout,
// reset values, command kinds and carrier structs.
// assumes nothing beyond a systemverilog compiler.
package dcte_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // geometry
   localparam int DCTE_BANKS  = 8;
   localparam int DCTE_BANK_W = 3;
   localparam int DCTE_ADDR_W = 8;
   localparam int DCTE_CNT_W  = 8;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [DCTE_ADDR_W-1:0] ROW_TIMING_ONE_OFS = 8'h00;
   localparam logic [DCTE_ADDR_W-1:0] ROW_TIMING_TWO_OFS = 8'h04;

   ////////////////////////////////////////////////////////////////////////////
   // row_timing_one fields
   localparam int WR_RECOVERY_LSB = 25;
   localparam int WR_RECOVERY_W   = 5;
   localparam int ROW_ACTIVE_LSB  = 18;
   localparam int ROW_ACTIVE_W    = 7;
   localparam int ROW_CYCLE_LSB   = 10;
   localparam int ROW_CYCLE_W     = 8;
   localparam int BANK_ACT_LSB    = 4;
   localparam int BANK_ACT_W      = 6;
   localparam int WR_TO_RD_LSB    = 0;
   localparam int WR_TO_RD_W      = 4;

   ////////////////////////////////////////////////////////////////////////////
   // row_timing_two fields
   localparam int RD_TO_WR_LSB    = 10;
   localparam int RD_TO_WR_W      = 3;
   localparam int PRE_PERIOD_LSB  = 5;
   localparam int PRE_PERIOD_W    = 5;
   localparam int ACT_ACCESS_LSB  = 0;
   localparam int ACT_ACCESS_W    = 5;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and writable masks
   localparam logic [31:0] ROW_TIMING_ONE_RESET = 32'h3fff_ffff;
   localparam logic [31:0] ROW_TIMING_ONE_MASK  = 32'h3fff_ffff;
   localparam logic [31:0] ROW_TIMING_TWO_RESET = 32'h0000_1fff;
   localparam logic [31:0] ROW_TIMING_TWO_MASK  = 32'h0000_1fff;

   ////////////////////////////////////////////////////////////////////////////
   // commands and carriers
   typedef enum logic [2:0] {
      DCTE_NOP,
      DCTE_ACT,
      DCTE_PRE,
      DCTE_RD,
      DCTE_WR,
      DCTE_REF
   } dcte_cmd_kind_type;

   typedef struct packed {
      logic                   valid;
      dcte_cmd_kind_type      kind;
      logic [DCTE_BANK_W-1:0] bank;
   } dcte_cmd_type;

   typedef struct packed {
      logic [DCTE_ADDR_W-1:0] addr;
      logic [31:0]            wdata;
      logic                   wr;
      logic                   rd;
   } dcte_bus_req_type;

endpackage : dcte_pkg

// ---- hdl/dcte_timer.sv ----
// one minimum-spacing timer: load starts it, busy stays high value cycles.
// assumes load pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dcte_timer
   import dcte_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // control
   input  wire logic                  load_i,
   input  wire logic [DCTE_CNT_W-1:0] value_i,
   // status
   output logic                       busy_o
);

   typedef struct packed {
      logic [DCTE_CNT_W-1:0] count;
   } dcte_timer_state_type;

   dcte_timer_state_type s;
   dcte_timer_state_type next_s;

   ////////////////////////////////////////////////////////////////////////////
   // reload wins over countdown so a later event restarts the spacing
   always_comb
   begin
      next_s = s;
      if (load_i)
      begin
         next_s.count = value_i;
      end
      else if (s.count != '0)
      begin
         next_s.count = s.count - 8'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign busy_o = (s.count != '0);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   timer_load_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      load_i |=> (s.count == $past(value_i)))
      else $error("timer did not take loaded value");

endmodule : dcte_timer

`default_nettype wire
